// ---- bsac_pkg.sv ----
package bsac_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_CONVERTER_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_CONVERTER_MODE     = 8'h04;
   localparam logic [7:0] OFS_FILTER_RATE        = 8'h08;
   localparam logic [7:0] OFS_HIGH_VOLTAGE       = 8'h0C;
   localparam logic [7:0] OFS_STATUS             = 8'h10;
   localparam logic [7:0] OFS_MASK               = 8'h14;
   localparam logic [7:0] OFS_CUR_RESULT         = 8'h18;
   localparam logic [7:0] OFS_VOLT_RESULT        = 8'h1C;
   localparam logic [7:0] OFS_TEMP_RESULT        = 8'h20;
   localparam logic [7:0] OFS_COUNT_LIMIT        = 8'h24;
   localparam logic [7:0] OFS_THRESHOLD          = 8'h28;
   localparam logic [7:0] OFS_ACCUM              = 8'h2C;
   localparam logic [7:0] OFS_OVR_LIMIT          = 8'h30;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CFG_CUR_EN   = 0;
   localparam int CFG_VOLT_EN  = 1;
   localparam int CFG_TEMP_EN  = 2;
   localparam int CFG_CNT_EN   = 3;
   localparam int CFG_CMP_EN   = 4;
   localparam int CFG_ACC_EN   = 5;
   localparam int CFG_OVR_EN   = 6;
   localparam int CFG_GSW_EN   = 7;
   localparam int MDE_CHOP     = 0;
   localparam int MDE_LOWPWR   = 1;
   localparam int MDE_TEMP_EXT = 2;
   localparam int MDE_GSW_RES  = 6;
   localparam int HV_ATTEN     = 7;
   localparam int ST_CUR_RDY   = 0;
   localparam int ST_VOLT_RDY  = 1;
   localparam int ST_TEMP_RDY  = 2;
   localparam int ST_CNT       = 3;
   localparam int ST_CMP       = 4;
   localparam int ST_OVR       = 5;
   localparam int ST_CUR_ERR   = 12;
   localparam int ST_VOLT_ERR  = 13;
   localparam int ST_TEMP_ERR  = 14;
   localparam int ST_IRQ_BITS  = 6;
   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [15:0] RST_FILTER_RATE = 16'h0007;
   localparam logic [15:0] RST_OVR_LIMIT   = 16'h00FF;
   localparam logic [1:0]  SETTLE_NOCHOP   = 2'h3;
   localparam logic [1:0]  SETTLE_CHOP     = 2'h2;
   localparam logic [7:0]  SINC_BASE_DEC   = 8'h40;
   localparam logic [15:0] POS_FULL        = 16'h7FFF;
   localparam logic [15:0] NEG_FULL        = 16'h8000;
endpackage : bsac_pkg

// ---- bsac_top.sv ----
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module bsac_top
   import bsac_pkg::*;
#(
   parameter int DEC_W = 50
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [31:0]      rdata,
   input  wire logic        cur_bit,
   input  wire logic        volt_bit,
   input  wire logic        temp_int_bit,
   input  wire logic        temp_ext_bit,
   output logic             atten_en,
   output logic             gsw_to_gnd,
   output logic             gsw_via_res,
   output logic             cur_valid,
   output logic             volt_valid,
   output logic             temp_valid,
   output logic             irq
);
   // ****************************************
   // Configuration registers
   // ****************************************
   logic [7:0]  converter_config_r;
   logic [7:0]  converter_mode_select_r;
   logic [15:0] filter_rate_setting_r;
   logic [7:0]  high_voltage_config_r;
   logic [15:0] mask_r;
   logic [15:0] status_r;
   logic [15:0] count_limit_r;
   logic [15:0] threshold_r;
   logic [15:0] ovr_limit_r;
   logic [15:0] conv_count_r;
   logic [31:0] accum_r;
   logic [15:0] res_r [3];
   logic [2:0]  valid_p;
   logic [2:0]  err_p;
   logic [2:0]  ch_en;
   logic [2:0]  bits_in;
   logic        ovr_hit;
   logic [15:0] ovr_run_r;
   logic        wr_status;

   // Decimation ratio from rate setting; low power slows the current channel fourfold
   function automatic logic [DEC_W-1:0] dec_ratio(input logic [15:0] rate, input logic lp);
      logic [DEC_W-1:0] r;
      r = DEC_W'(SINC_BASE_DEC) * (DEC_W'(rate[7:0]) + DEC_W'(1));
      if (lp) begin
         r = r << 2;
      end
      return r;
   endfunction : dec_ratio

   assign ch_en   = {converter_config_r[CFG_TEMP_EN], converter_config_r[CFG_VOLT_EN],
                     converter_config_r[CFG_CUR_EN]};
   assign bits_in = {(converter_mode_select_r[MDE_TEMP_EXT] ? temp_ext_bit : temp_int_bit),
                     volt_bit, cur_bit};
   assign wr_status = wr_stb && addr == OFS_STATUS;

   // ****************************************
   // Sinc3 decimators, one per channel
   // ****************************************
   for (genvar c = 0; c < 3; c++) begin : g_ch
      logic [DEC_W-1:0] i1_r, i2_r, i3_r, d1_r, d2_r, d3_r, cnt_r;
      logic [DEC_W-1:0] c1, c2, c3, ratio;
      logic [1:0]       settle_r;
      logic             en_d_r, src_d_r, vstb_r, errstb_r;
      logic signed [DEC_W:0] scaled;
      logic             restart;
      assign ratio   = dec_ratio(filter_rate_setting_r, c == 0 && converter_mode_select_r[MDE_LOWPWR]);
      assign restart = (ch_en[c] && !en_d_r) || (c == 2 && src_d_r != converter_mode_select_r[MDE_TEMP_EXT]);
      assign c1 = i3_r - d1_r;
      assign c2 = c1 - d2_r;
      assign c3 = c2 - d3_r;
      // Centre offset: full ratio cubed halved is mid-code, map into 16 bits
      assign scaled = $signed({1'b0, c3}) - $signed({1'b0, ratio * ratio * ratio >> 1});
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            i1_r     <= '0;
            i2_r     <= '0;
            i3_r     <= '0;
            d1_r     <= '0;
            d2_r     <= '0;
            d3_r     <= '0;
            cnt_r    <= '0;
            settle_r <= '0;
            en_d_r   <= 1'b0;
            src_d_r  <= 1'b0;
            vstb_r   <= 1'b0;
            errstb_r <= 1'b0;
            res_r[c] <= '0;
         end else begin
            en_d_r  <= ch_en[c];
            src_d_r <= converter_mode_select_r[MDE_TEMP_EXT];
            vstb_r  <= 1'b0;
            errstb_r <= 1'b0;
            if (!ch_en[c] || restart) begin
               i1_r  <= '0;
               i2_r  <= '0;
               i3_r  <= '0;
               d1_r  <= '0;
               d2_r  <= '0;
               d3_r  <= '0;
               cnt_r <= '0;
               settle_r <= converter_mode_select_r[MDE_CHOP] ? SETTLE_CHOP : SETTLE_NOCHOP;
            end else begin
               i1_r <= i1_r + DEC_W'(bits_in[c]);
               i2_r <= i2_r + i1_r;
               i3_r <= i3_r + i2_r;
               if (cnt_r >= ratio - DEC_W'(1)) begin
                  cnt_r <= '0;
                  d1_r <= i3_r;
                  d2_r <= c1;
                  d3_r <= c2;
                  if (settle_r > 2'd1) begin
                     settle_r <= settle_r - 2'd1;
                  end else begin
                     settle_r <= 2'd0;
                     vstb_r <= 1'b1;
                     if (scaled > $signed({{(DEC_W-15){1'b0}}, POS_FULL})) begin
                        res_r[c] <= POS_FULL;
                        errstb_r <= 1'b1;
                     end else if (scaled < -$signed({{(DEC_W-15){1'b0}}, POS_FULL}) - 1) begin
                        res_r[c] <= NEG_FULL;
                        errstb_r <= 1'b1;
                     end else begin
                        res_r[c] <= 16'(scaled);
                     end
                  end
               end else begin
                  cnt_r <= cnt_r + DEC_W'(1);
               end
            end
         end
      end
      assign valid_p[c] = vstb_r;
      assign err_p[c]   = errstb_r;
   end

   // ****************************************
   // Counter, comparator, accumulator, over-range
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_count_r <= '0;
         accum_r      <= '0;
      end else begin
         if (valid_p[0] && converter_config_r[CFG_CNT_EN]) begin
            conv_count_r <= (conv_count_r + 16'd1 >= count_limit_r) ? 16'd0 : conv_count_r + 16'd1;
         end
         if (!converter_config_r[CFG_ACC_EN]) begin
            accum_r <= '0;
         end else if (valid_p[0]) begin
            accum_r <= accum_r + {{16{res_r[0][15]}}, res_r[0]};
         end
      end
   end

   // Fast over-range watches raw bitstream runs, no filter latency
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ovr_run_r <= '0;
      end else if (!converter_config_r[CFG_OVR_EN] || !cur_bit) begin
         ovr_run_r <= '0;
      end else if (ovr_run_r != 16'hFFFF) begin
         ovr_run_r <= ovr_run_r + 16'd1;
      end
   end
   assign ovr_hit = converter_config_r[CFG_OVR_EN] && ovr_run_r == ovr_limit_r;

   // ****************************************
   // Status register, sticky with write-one-clear; error bits follow each conversion
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_r <= '0;
      end else begin
         for (int i = 0; i < 16; i++) begin
            logic set_b;
            logic clr_b;
            set_b = 1'b0;
            clr_b = wr_status && wdata[i];
            case (i)
               ST_CUR_RDY:  set_b = valid_p[0];
               ST_VOLT_RDY: set_b = valid_p[1];
               ST_TEMP_RDY: set_b = valid_p[2];
               ST_CNT:      set_b = valid_p[0] && converter_config_r[CFG_CNT_EN]
                                    && conv_count_r + 16'd1 >= count_limit_r;
               ST_CMP:      set_b = valid_p[0] && converter_config_r[CFG_CMP_EN]
                                    && $signed(res_r[0]) > $signed(threshold_r);
               ST_OVR:      set_b = ovr_hit;
               default:     set_b = 1'b0;
            endcase
            if (i < ST_CUR_ERR || i > ST_TEMP_ERR) begin
               if (set_b) begin
                  status_r[i] <= 1'b1;
               end else if (clr_b) begin
                  status_r[i] <= 1'b0;
               end
            end
         end
         for (int e = 0; e < 3; e++) begin
            if (valid_p[e]) begin
               status_r[ST_CUR_ERR+e] <= err_p[e];
            end
         end
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         converter_config_r      <= '0;
         converter_mode_select_r <= '0;
         filter_rate_setting_r   <= RST_FILTER_RATE;
         high_voltage_config_r   <= '0;
         mask_r                  <= '0;
         count_limit_r           <= '0;
         threshold_r             <= '0;
         ovr_limit_r             <= RST_OVR_LIMIT;
      end else if (wr_stb) begin
         case (addr)
            OFS_CONVERTER_CONFIG: converter_config_r      <= wdata[7:0];
            OFS_CONVERTER_MODE:   converter_mode_select_r <= wdata[7:0];
            OFS_FILTER_RATE:      filter_rate_setting_r   <= wdata[15:0];
            OFS_HIGH_VOLTAGE:     high_voltage_config_r   <= wdata[7:0];
            OFS_MASK:             mask_r                  <= wdata[15:0];
            OFS_COUNT_LIMIT:      count_limit_r           <= wdata[15:0];
            OFS_THRESHOLD:        threshold_r             <= wdata[15:0];
            OFS_OVR_LIMIT:        ovr_limit_r             <= wdata[15:0];
            default:              ;
         endcase
      end
   end

   // ****************************************
   // Read data, one cycle later
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd_stb) begin
         case (addr)
            OFS_CONVERTER_CONFIG: rdata <= {24'h0, converter_config_r};
            OFS_CONVERTER_MODE:   rdata <= {24'h0, converter_mode_select_r};
            OFS_FILTER_RATE:      rdata <= {16'h0, filter_rate_setting_r};
            OFS_HIGH_VOLTAGE:     rdata <= {24'h0, high_voltage_config_r};
            OFS_STATUS:           rdata <= {16'h0, status_r};
            OFS_MASK:             rdata <= {16'h0, mask_r};
            OFS_CUR_RESULT:       rdata <= {16'h0, res_r[0]};
            OFS_VOLT_RESULT:      rdata <= {16'h0, res_r[1]};
            OFS_TEMP_RESULT:      rdata <= {16'h0, res_r[2]};
            OFS_COUNT_LIMIT:      rdata <= {16'h0, count_limit_r};
            OFS_THRESHOLD:        rdata <= {16'h0, threshold_r};
            OFS_ACCUM:            rdata <= accum_r;
            OFS_OVR_LIMIT:        rdata <= {16'h0, ovr_limit_r};
            default:              rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ****************************************
   // Outputs from flip-flops
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         atten_en    <= 1'b0;
         gsw_to_gnd  <= 1'b0;
         gsw_via_res <= 1'b0;
         cur_valid   <= 1'b0;
         volt_valid  <= 1'b0;
         temp_valid  <= 1'b0;
         irq         <= 1'b0;
      end else begin
         atten_en    <= high_voltage_config_r[HV_ATTEN];
         gsw_to_gnd  <= converter_config_r[CFG_GSW_EN] && !converter_mode_select_r[MDE_GSW_RES];
         gsw_via_res <= converter_config_r[CFG_GSW_EN] && converter_mode_select_r[MDE_GSW_RES];
         cur_valid   <= valid_p[0];
         volt_valid  <= valid_p[1];
         temp_valid  <= valid_p[2];
         irq         <= |(status_r[ST_IRQ_BITS-1:0] & mask_r[ST_IRQ_BITS-1:0]);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   AST_ATTEN: assert property (@(posedge ref_clk) disable iff (rst)
      atten_en == $past(high_voltage_config_r[HV_ATTEN])) else $error("attenuator mismatch");
   AST_GSW_FLOAT: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(converter_config_r[CFG_GSW_EN]) |-> !gsw_to_gnd && !gsw_via_res)
      else $error("ground switch not floating");
   AST_GSW_MODE: assert property (@(posedge ref_clk) disable iff (rst)
      $past(converter_config_r[CFG_GSW_EN])
      |-> gsw_via_res == $past(converter_mode_select_r[MDE_GSW_RES])
          && gsw_to_gnd != $past(converter_mode_select_r[MDE_GSW_RES]))
      else $error("ground switch mode wrong");
   AST_VALID_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
      cur_valid |=> !cur_valid) else $error("valid longer than one cycle");
   AST_CLAMP: assert property (@(posedge ref_clk) disable iff (rst)
      valid_p[0] && err_p[0] |-> res_r[0] == POS_FULL || res_r[0] == NEG_FULL)
      else $error("out-of-range result not clamped");
   AST_ERR_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
      valid_p[1] |=> status_r[ST_VOLT_ERR] == $past(err_p[1])) else $error("error flag wrong");
   AST_ERR_CUR: assert property (@(posedge ref_clk) disable iff (rst)
      valid_p[0] |=> status_r[ST_CUR_ERR] == $past(err_p[0]))
      else $error("current error flag wrong");
   AST_CNT: assert property (@(posedge ref_clk) disable iff (rst)
      valid_p[0] && converter_config_r[CFG_CNT_EN] && conv_count_r == count_limit_r - 16'd1
      |=> status_r[ST_CNT] && conv_count_r == 16'd0) else $error("count limit missed");
   AST_OVR: assert property (@(posedge ref_clk) disable iff (rst)
      ovr_hit |=> status_r[ST_OVR]) else $error("over-range flag missing");
   AST_ACCUM: assert property (@(posedge ref_clk) disable iff (rst)
      valid_p[0] && converter_config_r[CFG_ACC_EN]
      |=> accum_r == $past(accum_r) + {{16{$past(res_r[0][15])}}, $past(res_r[0])})
      else $error("accumulator sum wrong");
   AST_CMP: assert property (@(posedge ref_clk) disable iff (rst)
      valid_p[0] && converter_config_r[CFG_CMP_EN] && $signed(res_r[0]) > $signed(threshold_r)
      |=> status_r[ST_CMP]) else $error("threshold flag missing");
   AST_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
      |(status_r[ST_IRQ_BITS-1:0] & mask_r[ST_IRQ_BITS-1:0]) |=> irq) else $error("irq missing");
endmodule : bsac_top

// ---- bsac_mod_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Modulator stream model
// ****************************************
// Pattern per channel: 0 alternating (mid scale), 1 all ones, 2 all zeros
module bsac_mod_model (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [7:0] pat,
   output logic            cur_bit,
   output logic            volt_bit,
   output logic            temp_int_bit,
   output logic            temp_ext_bit
);
   logic tgl_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tgl_r <= 1'b0;
      end else begin
         tgl_r <= ~tgl_r;
      end
   end

   function automatic logic pick(input logic [1:0] p, input logic t);
      case (p)
         2'h1: pick = 1'b1;
         2'h2: pick = 1'b0;
         default: pick = t;
      endcase
   endfunction : pick

   // One bitstream per channel
   assign cur_bit      = pick(pat[1:0], tgl_r);
   assign volt_bit     = pick(pat[3:2], tgl_r);
   assign temp_int_bit = pick(pat[5:4], tgl_r);
   assign temp_ext_bit = pick(pat[7:6], tgl_r);
endmodule : bsac_mod_model

// ---- test_bsac_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("[ERR] %s exp=%h got=%h", nm, exp, got); end end
module test_bsac_top;
   import bsac_pkg::*;
   logic        ref_clk, rst, wr_stb, rd_stb;
   logic [7:0]  addr, pat;
   logic [31:0] wdata, rdata, d, sum;
   logic        cur_bit, volt_bit, temp_int_bit, temp_ext_bit;
   logic        atten_en, gsw_to_gnd, gsw_via_res, irq;
   logic        cur_valid, volt_valid, temp_valid;
   wire  [2:0]  vld = {temp_valid, volt_valid, cur_valid};
   int          err_total, checked, n, i;

   bsac_top dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .cur_bit(cur_bit), .volt_bit(volt_bit),
      .temp_int_bit(temp_int_bit), .temp_ext_bit(temp_ext_bit), .atten_en(atten_en),
      .gsw_to_gnd(gsw_to_gnd), .gsw_via_res(gsw_via_res), .cur_valid(cur_valid),
      .volt_valid(volt_valid), .temp_valid(temp_valid), .irq(irq));
   bsac_mod_model mod_u (.ref_clk(ref_clk), .rst(rst), .pat(pat), .cur_bit(cur_bit),
      .volt_bit(volt_bit), .temp_int_bit(temp_int_bit), .temp_ext_bit(temp_ext_bit));

   // ****************************************
   // Bus and wait tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr   <= a;
      wdata  <= v;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask : rd

   task automatic wait_v(input int ch, output int cnt);
      cnt = 0;
      do begin
         @(posedge ref_clk);
         #1 cnt++;
      end while (vld[ch] !== 1'b1 && cnt < 4000);
      `CHK("valid_seen", 1'b1, vld[ch])
      @(posedge ref_clk);
      #1 `CHK("valid_pulse", 1'b0, vld[ch])
   endtask : wait_v

   task automatic settle(input int ch, input int per, input int dec);
      wait_v(ch, n);
      `CHK("settle", 1'b1, (n >= per * dec - 4 && n <= per * dec + 16))
   endtask : settle

   task automatic end_of_test;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial begin
      #(40 * 40000);
      err_total++;
      end_of_test;
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00; wdata = 32'h0; pat = 8'h00;
      err_total = 0; checked = 0; sum = 32'h0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd(OFS_FILTER_RATE, d);  `CHK("rate_rst", RST_FILTER_RATE, d[15:0])
      rd(OFS_OVR_LIMIT, d);    `CHK("ovr_rst", RST_OVR_LIMIT, d[15:0])
      rd(OFS_STATUS, d);       `CHK("status_rst", 32'h0, d)
      rd(8'h3C, d);            `CHK("unmapped", 32'h0, d)
      `CHK("irq_rst", 1'b0, irq)
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         wr(OFS_CONVERTER_CONFIG, {24'h0, i[1], 7'h0});
         wr(OFS_CONVERTER_MODE, {25'h0, i[0], 6'h0});
         @(posedge ref_clk);
         #1 `CHK("gsw_gnd", i[1] & ~i[0], gsw_to_gnd)
         `CHK("gsw_res", i[1] & i[0], gsw_via_res)
      end
      wr(OFS_HIGH_VOLTAGE, 32'h0080);
      @(posedge ref_clk);
      #1 `CHK("atten_on", 1'b1, atten_en)
      wr(OFS_HIGH_VOLTAGE, 32'h0);
      @(posedge ref_clk);
      #1 `CHK("atten_off", 1'b0, atten_en)
      $display("test pins done");
      wr(OFS_FILTER_RATE, 32'h0);
      for (i = 0; i < 6; i++) begin
         wr(OFS_CONVERTER_CONFIG, 32'h0);
         wr(OFS_CONVERTER_MODE, {31'h0, i[0]});
         wr(OFS_CONVERTER_CONFIG, 32'h1 << (i / 2));
         settle(i / 2, i[0] ? 2 : 3, 64);
      end
      wr(OFS_CONVERTER_CONFIG, 32'h0);
      wr(OFS_CONVERTER_MODE, 32'h0002);
      wr(OFS_CONVERTER_CONFIG, 32'h1);
      settle(0, 3, 256);
      $display("test settle done");
      pat = 8'h91;
      wr(OFS_CONVERTER_CONFIG, 32'h0);
      wr(OFS_CONVERTER_MODE, 32'h0);
      wr(OFS_CONVERTER_CONFIG, 32'h5);
      settle(2, 3, 64);
      rd(OFS_CUR_RESULT, d);   `CHK("cur_clamp", POS_FULL, d[15:0])
      rd(OFS_TEMP_RESULT, d);  `CHK("tint_clamp", POS_FULL, d[15:0])
      rd(OFS_STATUS, d);       `CHK("cur_err", 1'b1, d[ST_CUR_ERR])
      wr(OFS_CONVERTER_MODE, 32'h0004);
      settle(2, 3, 64);
      rd(OFS_TEMP_RESULT, d);  `CHK("text_clamp", NEG_FULL, d[15:0])
      rd(OFS_STATUS, d);       `CHK("temp_err", 1'b1, d[ST_TEMP_ERR])
      pat = 8'h00;
      repeat (4) wait_v(0, n);
      rd(OFS_STATUS, d);       `CHK("cur_err_clr", 1'b0, d[ST_CUR_ERR])
      $display("test clamp done");
      wr(OFS_CONVERTER_CONFIG, 32'h0);
      wr(OFS_COUNT_LIMIT, 32'h2);
      wr(OFS_MASK, 32'h0008);
      wr(OFS_STATUS, 32'h003F);
      wr(OFS_CONVERTER_CONFIG, 32'h0009);
      wait_v(0, n);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq_cnt1", 1'b0, irq)
      wait_v(0, n);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq_cnt2", 1'b1, irq)
      wr(OFS_STATUS, 32'h0008);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq_clr", 1'b0, irq)
      $display("test count done");
      pat = 8'h01;
      wr(OFS_CONVERTER_CONFIG, 32'h0);
      wr(OFS_THRESHOLD, 32'h1000);
      wr(OFS_MASK, 32'h0);
      wr(OFS_STATUS, 32'h003F);
      wr(OFS_CONVERTER_CONFIG, 32'h0031);
      for (i = 0; i < 3; i++) begin
         wait_v(0, n);
         rd(OFS_CUR_RESULT, d);
         sum = sum + {{16{d[15]}}, d[15:0]};
      end
      rd(OFS_ACCUM, d);        `CHK("accum", sum, d)
      rd(OFS_STATUS, d);       `CHK("cmp_flag", 1'b1, d[ST_CMP])
      `CHK("irq_masked", 1'b0, irq)
      wr(OFS_MASK, 32'h0010);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq_cmp", 1'b1, irq)
      $display("test compare done");
      wr(OFS_CONVERTER_CONFIG, 32'h0);
      wr(OFS_MASK, 32'h0);
      wr(OFS_OVR_LIMIT, 32'h0010);
      wr(OFS_STATUS, 32'h003F);
      wr(OFS_CONVERTER_CONFIG, 32'h0040);
      repeat (24) @(posedge ref_clk);
      rd(OFS_STATUS, d);       `CHK("ovr_set", 1'b1, d[ST_OVR])
      pat = 8'h00;
      wr(OFS_STATUS, 32'h003F);
      repeat (24) @(posedge ref_clk);
      rd(OFS_STATUS, d);       `CHK("ovr_quiet", 1'b0, d[ST_OVR])
      $display("test overrange done");
      end_of_test;
   end
endmodule : test_bsac_top
